// >>> hdl/ulmc_fifo.sv
`timescale 1ns/1ps
module ulmc_fifo #(
  parameter int W = 8,
  parameter int D = 4,
  localparam int AW = $clog2(D),
  localparam int CW = $clog2(D + 1)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [CW-1:0] count
);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } ulmc_fifo_st_t;

  ulmc_fifo_st_t s_r, s_nxt;
  logic push;
  logic pop;

  // Handshake view of the state; full refuses, empty withholds
  assign in_ready = s_r.cnt != CW'(D);
  assign out_valid = s_r.cnt != '0;
  assign out_data = s_r.mem[s_r.rp];
  assign count = s_r.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and level update; flush beats any push or pop
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == AW'(D - 1)) ? '0 : s_r.wp + AW'(1);
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(D - 1)) ? '0 : s_r.rp + AW'(1);
    end
    s_nxt.cnt = s_r.cnt + CW'(push) - CW'(pop);
    if (flush) begin
      s_nxt.wp = '0;
      s_nxt.rp = '0;
      s_nxt.cnt = '0;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// >>> hdl/ulmc_pkg.sv
package ulmc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_DIV_HIGH = 3'h1;
  localparam logic [2:0] OFS_FIFO = 3'h2;
  localparam logic [2:0] OFS_LINE = 3'h3;
  localparam logic [2:0] OFS_MODEM = 3'h4;
  localparam logic [2:0] OFS_LSTAT = 3'h5;
  localparam logic [2:0] OFS_MSTAT = 3'h6;
  localparam logic [2:0] OFS_SCRATCH = 3'h7;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int LF_STOP = 2;
  localparam int LF_PAR_EN = 3;
  localparam int LF_EVEN = 4;
  localparam int LF_FORCE = 5;
  localparam int LF_BREAK = 6;
  localparam int LF_DLAB = 7;
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_BANK = 2;
  localparam int MC_OP2 = 3;
  localparam int MC_LOOP = 4;
  localparam int MC_XANY = 5;
  localparam int MC_IR = 6;
  localparam int MC_PRESC = 7;
  localparam int EF_SWFLOW = 3;
  localparam int EF_ENH = 4;
  localparam int EF_ARTS = 6;
  localparam int EF_ACTS = 7;
  localparam int FC_EN = 0;
  localparam int FC_RXRST = 1;
  localparam int FC_TXRST = 2;

  // ****************************************
  // Reset values and tables
  // ****************************************
  localparam logic [7:0] LINE_RST = 8'h05;
  localparam logic [7:0] SCRATCH_RST = 8'hFF;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [3:0][6:0] RX_TRIG_LVL = {7'h3C, 7'h38, 7'h10, 7'h08};
  localparam logic [3:0][6:0] TX_TRIG_LVL = {7'h38, 7'h20, 7'h10, 7'h08};

  // ****************************************
  // Timing counts, in 16x sample ticks except the prescaler (clocks) and the timeout terms (characters, bits)
  // ****************************************
  localparam logic [1:0] PRESC_LAST = 2'h3;
  localparam logic [3:0] START_MID = 4'h7;
  localparam logic [4:0] BIT_END = 5'h0F;
  localparam logic [4:0] STOP_ONE_END = 5'h0F;
  localparam logic [4:0] STOP_HALF_END = 5'h17;
  localparam logic [4:0] STOP_TWO_END = 5'h1F;
  localparam logic [4:0] IR_PULSE = 5'h03;
  localparam logic [4:0] IR_HOLD = 5'h10;
  localparam int TOUT_CHARS = 4;
  localparam int TOUT_BITS = 12;
  localparam int TICKS_PER_BIT = 16;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulmc_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ulmc_rx_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ulmc_reg_req_t;

  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } ulmc_modem_in_t;

endpackage

// >>> hdl/ulmc_top.sv
`timescale 1ns/1ps
module ulmc_top #(
  parameter int DEPTH = 4,
  parameter logic [7:0] XON_CHAR = 8'h11,
  parameter logic [7:0] XOFF_CHAR = 8'h13
) (
  input wire logic clk,
  input wire logic rst,
  input wire ulmc_pkg::ulmc_reg_req_t req,
  output logic [7:0] rdata,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire ulmc_pkg::ulmc_modem_in_t modem_in,
  output logic dtr_n,
  output logic rts_n,
  output logic rx_irq,
  output logic tx_irq
);
  import ulmc_pkg::*;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [7:0] line;
    logic [7:0] modem_control;
    logic [7:0] enhanced_feature_control;
    logic [7:0] scratch;
    logic [7:0] thresh;
    logic [7:0] tlev;
    logic [15:0] div;
    logic fifo_en;
    logic [1:0] rx_trig;
    logic [1:0] tx_trig;
    logic [7:0] rdata;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [3:0] mprev;
    logic [3:0] mdelta;
    logic [1:0] pre_cnt;
    logic [15:0] baud_cnt;
    ulmc_tx_state_t tx_st;
    logic [7:0] tx_sh;
    logic [4:0] tx_tick;
    logic [2:0] tx_bit;
    logic tx_par;
    logic tx_line;
    ulmc_rx_state_t rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_tick;
    logic [2:0] rx_bit;
    logic rx_par;
    logic [4:0] ir_hold;
    logic [10:0] tout;
    logic tout_flag;
    logic overrun;
    logic perr;
    logic halted;
    logic tx_pin;
    logic dtr_n;
    logic rts_n;
    logic rx_irq;
    logic tx_irq;
  } ulmc_top_st_t;

  ulmc_top_st_t s_r, s_nxt;

  // ****************************************
  // Parity of a character under the line format
  // ****************************************
  function automatic logic par_of(input logic [7:0] d, input logic [7:0] lf);
    logic [7:0] m;
    m = d & (8'hFF >> (2'h3 - lf[1:0]));
    if (lf[LF_FORCE]) begin
      par_of = ~lf[LF_EVEN];
    end else begin
      par_of = lf[LF_EVEN] ? ^m : ~^m;
    end
  endfunction

  // ****************************************
  // Data FIFOs
  // ****************************************
  logic tx_in_valid, tx_in_ready, tx_out_valid, tx_out_ready;
  logic [7:0] tx_out_data;
  logic [CW-1:0] tx_count;
  logic rx_in_valid, rx_in_ready, rx_out_valid, rx_out_ready;
  logic [7:0] rx_in_data, rx_out_data;
  logic [CW-1:0] rx_count;
  logic tx_flush, rx_flush;

  ulmc_fifo #(.W(8), .D(DEPTH)) u_tx_fifo (
    .clk(clk),
    .rst(rst),
    .flush(tx_flush),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .in_data(req.wdata),
    .out_valid(tx_out_valid),
    .out_ready(tx_out_ready),
    .out_data(tx_out_data),
    .count(tx_count)
  );

  ulmc_fifo #(.W(8), .D(DEPTH)) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .flush(rx_flush),
    .in_valid(rx_in_valid),
    .in_ready(rx_in_ready),
    .in_data(rx_in_data),
    .out_valid(rx_out_valid),
    .out_ready(rx_out_ready),
    .out_data(rx_out_data),
    .count(rx_count)
  );

  // ****************************************
  // Decoded controls
  // ****************************************
  logic dlab, bank, loop, ir, sw_flow, tick, pre_tick, cts_off;
  logic [15:0] div_last;
  logic [2:0] last_bit;
  logic [4:0] stop_end;
  logic [3:0] frame_bits;
  logic [10:0] tout_last;
  logic [3:0] mstat;
  logic rx_line, rx_done, rx_store;
  logic [7:0] rx_char;
  logic wr_fcr, rd_msr, rd_lsr;

  assign dlab = s_r.line[LF_DLAB];
  assign bank = s_r.enhanced_feature_control[EF_ENH] && s_r.modem_control[MC_BANK];
  assign loop = s_r.modem_control[MC_LOOP];
  assign ir = s_r.modem_control[MC_IR];
  assign sw_flow = s_r.enhanced_feature_control[EF_SWFLOW];
  assign cts_off = s_r.enhanced_feature_control[EF_ACTS] && !mstat[0];
  assign last_bit = 3'h4 + {1'b0, s_r.line[1:0]};
  // One stop, or 1.5 for 5-bit words and 2 otherwise
  assign stop_end = !s_r.line[LF_STOP] ? STOP_ONE_END
                  : (s_r.line[1:0] == 2'h0) ? STOP_HALF_END : STOP_TWO_END;
  assign frame_bits = 4'h7 + {2'h0, s_r.line[1:0]} + {3'h0, s_r.line[LF_PAR_EN]} + {3'h0, s_r.line[LF_STOP]};
  assign tout_last = 11'((TOUT_CHARS * int'(frame_bits) + TOUT_BITS) * TICKS_PER_BIT - 1);
  assign div_last = (s_r.div == '0) ? '0 : s_r.div - 16'h0001;

  // Prescaler gates the baud counter; tick is the 16x sample strobe
  assign pre_tick = !s_r.modem_control[MC_PRESC] || (s_r.pre_cnt == PRESC_LAST);
  assign tick = pre_tick && (s_r.baud_cnt >= div_last);

  // Modem status: pins normally, control bits in loopback
  assign mstat = loop ? {s_r.modem_control[MC_OP2], s_r.modem_control[MC_BANK], s_r.modem_control[MC_DTR], s_r.modem_control[MC_RTS]}
                      : ~s_r.sync2[4:1];

  // Receive line source: internal loop, infrared decode or the pin
  assign rx_line = loop ? (s_r.tx_line && !s_r.line[LF_BREAK])
                 : ir ? (s_r.ir_hold == '0) : s_r.sync2[0];

  // Received character end, right aligned for short words
  assign rx_done = tick && (s_r.rx_st == RX_STOP) && (s_r.rx_tick == BIT_END[3:0]);
  assign rx_char = s_r.rx_sh >> (2'h3 - s_r.line[1:0]);
  // Flow characters are swallowed while software flow is on
  assign rx_store = !(sw_flow && (rx_char == XON_CHAR || rx_char == XOFF_CHAR));
  assign rx_in_valid = rx_done && rx_store;
  assign rx_in_data = rx_char;

  // Register port strobes
  assign tx_in_valid = req.wr && (req.addr == OFS_DATA) && !dlab;
  assign rx_out_ready = req.rd && (req.addr == OFS_DATA) && !dlab;
  assign wr_fcr = req.wr && (req.addr == OFS_FIFO) && !dlab;
  assign rx_flush = wr_fcr && req.wdata[FC_EN] && req.wdata[FC_RXRST];
  assign tx_flush = wr_fcr && req.wdata[FC_EN] && req.wdata[FC_TXRST];
  assign rd_msr = req.rd && (req.addr == OFS_MSTAT) && !bank;
  assign rd_lsr = req.rd && (req.addr == OFS_LSTAT);
  // Transmitter takes a character only on a tick while free to send
  assign tx_out_ready = (s_r.tx_st == TX_IDLE) && tick && !s_r.halted && !cts_off;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    s_nxt = s_r;

    // Input synchronisers, rx pin and modem pins
    s_nxt.sync1 = {modem_in.cd_n, modem_in.ri_n, modem_in.dsr_n, modem_in.cts_n, rx_pin};
    s_nxt.sync2 = s_r.sync1;

    // Baud generation
    s_nxt.pre_cnt = s_r.pre_cnt + 2'h1;
    if (tick) begin
      s_nxt.baud_cnt = '0;
    end else if (pre_tick) begin
      s_nxt.baud_cnt = s_r.baud_cnt + 16'h0001;
    end

    // Register writes
    if (req.wr) begin
      unique case (req.addr)
        OFS_DATA: if (dlab) s_nxt.div[7:0] = req.wdata;
        OFS_DIV_HIGH: if (dlab) s_nxt.div[15:8] = req.wdata;
        OFS_FIFO: begin
          if (dlab) begin
            s_nxt.enhanced_feature_control = req.wdata;
          end else if (req.wdata[FC_EN]) begin
            s_nxt.fifo_en = 1'b1;
            s_nxt.rx_trig = req.wdata[7:6];
            s_nxt.tx_trig = req.wdata[5:4];
          end else begin
            s_nxt.fifo_en = 1'b0;
          end
        end
        OFS_LINE: s_nxt.line = req.wdata;
        OFS_MODEM: begin
          s_nxt.modem_control[4:0] = req.wdata[4:0];
          if (s_r.enhanced_feature_control[EF_ENH]) begin
            s_nxt.modem_control[7:5] = req.wdata[7:5];
          end
        end
        OFS_LSTAT: ;
        OFS_MSTAT: if (bank) s_nxt.thresh = req.wdata;
        OFS_SCRATCH: begin
          if (bank) begin
            s_nxt.tlev = req.wdata;
          end else begin
            s_nxt.scratch = req.wdata;
          end
        end
      endcase
    end

    // Register reads, answered one cycle later
    if (req.rd) begin
      unique case (req.addr)
        OFS_DATA: s_nxt.rdata = dlab ? s_r.div[7:0] : (rx_out_valid ? rx_out_data : 8'h00);
        OFS_DIV_HIGH: s_nxt.rdata = dlab ? s_r.div[15:8] : 8'h00;
        OFS_FIFO: s_nxt.rdata = dlab ? s_r.enhanced_feature_control : {s_r.fifo_en, s_r.fifo_en, 5'h00, !(s_r.rx_irq || s_r.tx_irq)};
        OFS_LINE: s_nxt.rdata = s_r.line;
        OFS_MODEM: s_nxt.rdata = s_r.modem_control;
        OFS_LSTAT: s_nxt.rdata = {1'b0, (tx_count == '0) && (s_r.tx_st == TX_IDLE), tx_count == '0,
                                  2'h0, s_r.perr, s_r.overrun, rx_out_valid};
        OFS_MSTAT: s_nxt.rdata = bank ? s_r.thresh : {mstat, s_r.mdelta};
        OFS_SCRATCH: s_nxt.rdata = bank ? s_r.tlev : s_r.scratch;
      endcase
    end

    // Modem deltas; a new change wins over the read that clears
    s_nxt.mprev = mstat;
    s_nxt.mdelta = (rd_msr ? 4'h0 : s_r.mdelta)
                 | {mstat[3] ^ s_r.mprev[3], s_r.mprev[2] && !mstat[2],
                    mstat[1] ^ s_r.mprev[1], mstat[0] ^ s_r.mprev[0]};

    // Transmit serializer
    if (tx_out_ready && tx_out_valid) begin
      s_nxt.tx_st = TX_START;
      s_nxt.tx_sh = tx_out_data;
      s_nxt.tx_par = par_of(tx_out_data, s_r.line);
      s_nxt.tx_tick = '0;
      s_nxt.tx_line = 1'b0;
    end else if (tick && s_r.tx_st != TX_IDLE) begin
      s_nxt.tx_tick = s_r.tx_tick + 5'h01;
      if (s_r.tx_st == TX_STOP) begin
        if (s_r.tx_tick == stop_end) s_nxt.tx_st = TX_IDLE;
      end else if (s_r.tx_tick == BIT_END) begin
        s_nxt.tx_tick = '0;
        unique case (s_r.tx_st)
          TX_START: begin
            s_nxt.tx_st = TX_DATA;
            s_nxt.tx_bit = '0;
            s_nxt.tx_line = s_r.tx_sh[0];
          end
          TX_DATA: begin
            if (s_r.tx_bit == last_bit) begin
              s_nxt.tx_st = s_r.line[LF_PAR_EN] ? TX_PAR : TX_STOP;
              s_nxt.tx_line = s_r.line[LF_PAR_EN] ? s_r.tx_par : 1'b1;
            end else begin
              s_nxt.tx_bit = s_r.tx_bit + 3'h1;
              s_nxt.tx_sh = s_r.tx_sh >> 1;
              s_nxt.tx_line = s_r.tx_sh[1];
            end
          end
          TX_PAR: begin
            s_nxt.tx_st = TX_STOP;
            s_nxt.tx_line = 1'b1;
          end
          default: s_nxt.tx_st = TX_IDLE;
        endcase
      end
    end

    // Infrared receive pulse stretch, one bit time per pulse
    if (ir && s_r.sync2[0]) begin
      s_nxt.ir_hold = IR_HOLD;
    end else if (tick && s_r.ir_hold != '0) begin
      s_nxt.ir_hold = s_r.ir_hold - 5'h01;
    end

    // Receive deserializer, mid-bit sampling at 16x
    if (tick) begin
      s_nxt.rx_tick = s_r.rx_tick + 4'h1;
      unique case (s_r.rx_st)
        RX_IDLE: begin
          s_nxt.rx_tick = '0;
          if (!rx_line) s_nxt.rx_st = RX_START;
        end
        RX_START: begin
          if (s_r.rx_tick == START_MID) begin
            s_nxt.rx_tick = '0;
            s_nxt.rx_bit = '0;
            s_nxt.rx_st = rx_line ? RX_IDLE : RX_DATA; // glitch rejection
          end
        end
        RX_DATA: begin
          if (s_r.rx_tick == BIT_END[3:0]) begin
            s_nxt.rx_sh = {rx_line, s_r.rx_sh[7:1]};
            s_nxt.rx_bit = s_r.rx_bit + 3'h1;
            if (s_r.rx_bit == last_bit) s_nxt.rx_st = s_r.line[LF_PAR_EN] ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: begin
          if (s_r.rx_tick == BIT_END[3:0]) begin
            s_nxt.rx_par = rx_line;
            s_nxt.rx_st = RX_STOP;
          end
        end
        RX_STOP: if (s_r.rx_tick == BIT_END[3:0]) s_nxt.rx_st = RX_IDLE;
      endcase
    end

    // Parity and overrun flags; a new error wins over the clearing read
    s_nxt.perr = (rd_lsr ? 1'b0 : s_r.perr)
               | (rx_done && s_r.line[LF_PAR_EN] && (s_r.rx_par != par_of(rx_char, s_r.line)));
    s_nxt.overrun = (rd_lsr ? 1'b0 : s_r.overrun) | (rx_in_valid && !rx_in_ready);

    // Software flow halt and resume
    if (rx_done) begin
      if (sw_flow && rx_char == XOFF_CHAR) begin
        s_nxt.halted = 1'b1;
      end else if ((sw_flow && rx_char == XON_CHAR) || s_r.modem_control[MC_XANY]) begin
        s_nxt.halted = 1'b0;
      end
    end
    if (!sw_flow && !s_r.modem_control[MC_XANY]) s_nxt.halted = 1'b0;

    // Receive timeout: idle data sitting in the FIFO
    if (rx_count == '0 || rx_in_valid || rx_out_ready) begin
      s_nxt.tout = '0;
    end else if (tick && s_r.tout != tout_last) begin
      s_nxt.tout = s_r.tout + 11'h001;
      if (s_r.tout + 11'h001 == tout_last) s_nxt.tout_flag = 1'b1;
    end
    if (rx_out_ready || rx_count == '0) s_nxt.tout_flag = 1'b0;

    // Pin and interrupt outputs, all registered
    s_nxt.tx_pin = loop ? 1'b1
                 : s_r.line[LF_BREAK] ? 1'b0
                 : ir ? (!s_r.tx_line && s_r.tx_st != TX_IDLE && s_r.tx_tick < IR_PULSE)
                 : s_r.tx_line;
    s_nxt.dtr_n = loop ? 1'b1 : !s_r.modem_control[MC_DTR];
    if (loop) begin
      s_nxt.rts_n = 1'b1;
    end else if (s_r.enhanced_feature_control[EF_ARTS]) begin
      // Auto flow: drop at halt level, restore at resume level
      if (7'(rx_count) >= {1'b0, s_r.thresh[3:0], 2'h0}) begin
        s_nxt.rts_n = 1'b1;
      end else if (7'(rx_count) <= {1'b0, s_r.thresh[7:4], 2'h0}) begin
        s_nxt.rts_n = 1'b0;
      end
    end else begin
      s_nxt.rts_n = !s_r.modem_control[MC_RTS];
    end
    s_nxt.rx_irq = (7'(rx_count) > RX_TRIG_LVL[s_r.rx_trig]) || s_r.tout_flag;
    s_nxt.tx_irq = (7'(DEPTH) - 7'(tx_count)) > TX_TRIG_LVL[s_r.tx_trig];
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.line <= LINE_RST;
      s_r.scratch <= SCRATCH_RST;
      s_r.div <= DIV_RST;
      s_r.sync1 <= 5'h1F;
      s_r.sync2 <= 5'h1F;
      s_r.tx_line <= 1'b1;
      s_r.tx_pin <= 1'b1;
      s_r.dtr_n <= 1'b1;
      s_r.rts_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign tx_pin = s_r.tx_pin;
  assign dtr_n = s_r.dtr_n;
  assign rts_n = s_r.rts_n;
  assign rx_irq = s_r.rx_irq;
  assign tx_irq = s_r.tx_irq;
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import ulmc_pkg::*;
  logic clk, rst, rx_pin, tx_pin, dtr_n, rts_n, rx_irq, tx_irq;
  logic [7:0] rdata, d, c;
  ulmc_reg_req_t req;
  ulmc_modem_in_t modem_in;
  logic [11:0] s, e, m;
  int failures, tests_run, n, p, bt, len, x;
  logic [7:0] lc [9] = '{8'h03, 8'h0B, 8'h1B, 8'h2B, 8'h3B, 8'h00, 8'h04, 8'h07, 8'h03};
  ulmc_top ulmc_top_i (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .modem_in(modem_in), .dtr_n(dtr_n), .rts_n(rts_n), .rx_irq(rx_irq), .tx_irq(tx_irq));
  ulmc_peer ulmc_peer_i (.clk(clk), .tx_line(tx_pin), .rx_line(rx_pin));
  // ****
  // Access tasks, driven on the falling edge
  // ****
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= v;
    @(negedge clk);
    req.wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [2:0] a);
    req.rd <= 1'b1;
    req.addr <= a;
    @(negedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    tests_run++;
    if (got !== ex) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] ex, input logic [7:0] mk, input string nm);
    rd(a);
    chk(nm, 16'(ex & mk), 16'(d & mk));
  endtask
  // Poll line_status; a spent bound ends the run
  task automatic wt(input logic [7:0] mk);
    int t;
    t = 0;
    d = 8'h00;
    while ((d & mk) == 8'h00) begin
      rd(OFS_LSTAT);
      t++;
      if (t > 2000) begin
        failures++;
        end_of_test();
      end
    end
  endtask
  task automatic end_of_test;
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  initial begin
    failures = 0;
    tests_run = 0;
    rst = 1'b1;
    req = '0;
    modem_in = '1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rc(OFS_LINE, 8'h05, 8'hFF, "line_format");
    rc(OFS_SCRATCH, 8'hFF, 8'hFF, "scratch_pad");
    rc(OFS_LSTAT, 8'h60, 8'hFF, "line_status");
    wr(OFS_SCRATCH, 8'hA5);
    rc(OFS_SCRATCH, 8'hA5, 8'hFF, "scratch_pad");
    wr(OFS_MODEM, 8'h03);
    chk("dtr_n", 16'h0, 16'(dtr_n));
    chk("rts_n", 16'h0, 16'(rts_n));
    wr(OFS_MODEM, 8'hE0);
    rc(OFS_MODEM, 8'h00, 8'hFF, "modem_control");
    wr(OFS_LINE, 8'h83);
    wr(OFS_FIFO, 8'h10);
    wr(OFS_DIV_HIGH, 8'h12);
    rc(OFS_DIV_HIGH, 8'h12, 8'hFF, "divisor_high");
    wr(OFS_DIV_HIGH, 8'h00);
    wr(OFS_LINE, 8'h03);
    rc(OFS_DIV_HIGH, 8'h00, 8'hFF, "offset 1");
    wr(OFS_MODEM, 8'hE0);
    rc(OFS_MODEM, 8'hE0, 8'hFF, "modem_control");
    wr(OFS_MODEM, 8'h04);
    wr(OFS_MSTAT, 8'h5A);
    rc(OFS_MSTAT, 8'h5A, 8'hFF, "flow_threshold");
    wr(OFS_SCRATCH, 8'h3C);
    rc(OFS_SCRATCH, 8'h3C, 8'hFF, "fifo_trigger_level");
    wr(OFS_MODEM, 8'h00);
    rc(OFS_SCRATCH, 8'hA5, 8'hFF, "scratch_pad");
    rc(OFS_MSTAT, 8'h00, 8'hF0, "modem_status");
    // Frame formats, two characters back to back; last entry prescaled
    for (int i = 0; i < 9; i++) begin
      c = lc[i];
      n = 5 + int'(c[1:0]);
      p = int'(c[3]);
      bt = (i == 8) ? 64 : 16;
      x = ((1 + n + p) * 16 + (!c[2] ? 16 : (n == 5 ? 24 : 32))) * bt / 16;
      e = 12'(8'h4D & 8'((1 << n) - 1));
      if (p == 1)
        e[n] = c[5] ? !c[4] : (c[4] ^ ~^e[7:0]);
      e[n + p] = 1'b1;
      m = 12'((1 << (n + p + 1)) - 1);
      if (i == 8)
        wr(OFS_MODEM, 8'h80);
      wr(OFS_LINE, c);
      fork
        ulmc_peer_i.grab(bt, (1 + n + p) * bt, s, len);
        begin
          wr(OFS_DATA, 8'h4D);
          wr(OFS_DATA, 8'h4D);
        end
      join
      chk("frame", 16'(e), 16'(s & m));
      chk("length", 16'(x), 16'(len >= x && len < x + bt / 4 ? x : len));
      if (len == 0)
        end_of_test();
      wt(8'h40);
    end
    wr(OFS_MODEM, 8'h00);
    wr(OFS_LINE, 8'h43);
    chk("tx_pin", 16'h0, 16'(tx_pin));
    wr(OFS_LINE, 8'h83);
    wr(OFS_FIFO, 8'h00);
    wr(OFS_LINE, 8'h03);
    chk("tx_pin", 16'h1, 16'(tx_pin));
    // Loopback: status mirrors control bits, data returns
    wr(OFS_MODEM, 8'h1F);
    rc(OFS_MSTAT, 8'hF0, 8'hF0, "modem_status");
    wr(OFS_MODEM, 8'h10);
    rc(OFS_MSTAT, 8'h00, 8'hF0, "modem_status");
    wr(OFS_DATA, 8'hA6);
    wt(8'h01);
    chk("rx_irq", 16'h0, 16'(rx_irq));
    // Unread character left sitting past the timeout
    repeat (900) @(negedge clk);
    chk("rx_irq", 16'h1, 16'(rx_irq));
    rc(OFS_DATA, 8'hA6, 8'hFF, "receive_holding");
    chk("rx_irq", 16'h0, 16'(rx_irq));
    rc(OFS_LSTAT, 8'h00, 8'h01, "line_status");
    wr(OFS_MODEM, 8'h00);
    // Peer sends a character with bad even parity
    wr(OFS_LINE, 8'h1B);
    ulmc_peer_i.send(8'hC3, 1'b1, 16);
    wt(8'h01);
    chk("line_status", 16'h05, 16'(d & 8'h05));
    rc(OFS_DATA, 8'hC3, 8'hFF, "receive_holding");
    rc(OFS_LSTAT, 8'h00, 8'h01, "line_status");
    end_of_test();
  end
endmodule

// >>> verification/ulmc_monitor.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module ulmc_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire ulmc_pkg::ulmc_reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rx_pin,
  input wire logic tx_pin,
  input wire ulmc_pkg::ulmc_modem_in_t modem_in,
  input wire logic dtr_n,
  input wire logic rts_n,
  input wire logic rx_irq,
  input wire logic tx_irq
);
  import ulmc_pkg::*;
  logic [7:0] lcr_r;
  logic [7:0] mcr_r;
  logic [7:0] efr_r;
  logic [3:0] lb;
  logic brk;
  logic bank;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Shadows rebuilt from writes, so no peeking into the design
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lcr_r <= LINE_RST;
      mcr_r <= 8'h00;
      efr_r <= 8'h00;
    end else if (req.wr) begin
      if (req.addr == OFS_LINE)
        lcr_r <= req.wdata;
      if (req.addr == OFS_MODEM)
        mcr_r <= efr_r[EF_ENH] ? req.wdata : {mcr_r[7:5], req.wdata[4:0]};
      if (req.addr == OFS_FIFO && lcr_r[LF_DLAB])
        efr_r <= req.wdata;
    end
  end
  // Derived conditions
  assign brk = lcr_r[LF_BREAK] && !mcr_r[MC_LOOP];
  assign bank = efr_r[EF_ENH] && mcr_r[MC_BANK];
  assign lb = {mcr_r[MC_OP2], mcr_r[MC_BANK], mcr_r[MC_DTR], mcr_r[MC_RTS]};
  sequence sp_write;
    req.wr && req.addr == OFS_SCRATCH && !bank;
  endsequence
  sequence sp_read;
    req.rd && !req.wr && req.addr == OFS_SCRATCH && !bank;
  endsequence
  chk_break_low: assert property (brk [*3] |-> !tx_pin) else $error("tx not low in break");
  chk_loop_pins: assert property (mcr_r[MC_LOOP] [*3] |-> tx_pin && dtr_n && rts_n)
    else $error("pins not idle in loopback");
  chk_dtr_drive: assert property (!mcr_r[MC_LOOP] && mcr_r == $past(mcr_r) |-> dtr_n == !mcr_r[MC_DTR])
    else $error("dtr_n wrong");
  chk_rts_drive: assert property (!mcr_r[MC_LOOP] && !efr_r[EF_ARTS] && mcr_r == $past(mcr_r)
    |-> rts_n == !mcr_r[MC_RTS]) else $error("rts_n wrong");
  chk_scratch_back: assert property (sp_write ##2 sp_read |=> rdata == $past(req.wdata, 3))
    else $error("scratch readback wrong");
  chk_msr_loop: assert property (req.rd && !req.wr && req.addr == OFS_MSTAT && mcr_r[MC_LOOP] && !bank
    |=> rdata[7:4] == $past(lb)) else $error("loopback status wrong");
  chk_div_hidden: assert property (req.rd && req.addr == OFS_DIV_HIGH && !lcr_r[LF_DLAB] |=> rdata == 8'h00)
    else $error("offset 1 not zero");
  chk_mcr_gate: assert property (req.rd && !req.wr && req.addr == OFS_MODEM |=> rdata == $past(mcr_r))
    else $error("modem_control readback wrong");
  chk_tx_irq_off: assert property (!tx_irq) else $error("tx_irq with few spaces");
endmodule
bind ulmc_top ulmc_monitor ulmc_monitor_i (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rx_pin(rx_pin),
  .tx_pin(tx_pin), .modem_in(modem_in), .dtr_n(dtr_n), .rts_n(rts_n), .rx_irq(rx_irq), .tx_irq(tx_irq));

// >>> verification/ulmc_peer.sv
`timescale 1ns/1ps
// ****
// Remote serial peer
// ****
module ulmc_peer (
  input wire logic clk,
  input wire logic tx_line,
  output logic rx_line
);
  // Mark level while idle
  initial rx_line = 1'b1;
  // One 8-bit frame with a chosen parity bit, bt clocks a bit
  task automatic send(input logic [7:0] dv, input logic pv, input int bt);
    logic [10:0] f;
    f = {1'b1, pv, dv, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(negedge clk);
      rx_line <= f[i];
      repeat (bt - 1) @(negedge clk);
    end
  endtask
  // Mid-bit samples, and time from start to the next start bit
  // Looks on the falling edge, clear of the edge that moves the pin
  task automatic grab(input int bt, input int minc, output logic [11:0] s, output int len);
    int t;
    t = 0;
    len = 0;
    while (tx_line !== 1'b0 && t < 4000) begin
      @(negedge clk);
      t++;
    end
    for (int c = 1; c < 16 * bt; c++) begin
      @(negedge clk);
      if (c % bt == bt / 2 && c / bt >= 1 && c / bt <= 12)
        s[c / bt - 1] = tx_line;
      if (!tx_line && c > minc && len == 0)
        len = c;
    end
  endtask
endmodule
